/* File: rtl/sfr_pkg.sv */
// opcodes, field layout, timing and state types of the flash read engine
package sfr_pkg;

  // ************************************************************
  // opcodes
  // ************************************************************
  localparam logic [7:0] OP_PAGE_READ = 8'h52;
  localparam logic [7:0] OP_XFER1 = 8'h53;
  localparam logic [7:0] OP_BUF1_READ = 8'h54;
  localparam logic [7:0] OP_XFER2 = 8'h55;
  localparam logic [7:0] OP_BUF2_READ = 8'h56;
  localparam logic [7:0] OP_STATUS = 8'h57;
  localparam logic [7:0] OP_CMP1 = 8'h60;
  localparam logic [7:0] OP_CMP2 = 8'h61;

  // ************************************************************
  // header layout, counted in serial clock rising edges
  // ************************************************************
  localparam logic [6:0] CNT_OPCODE_LAST = 7'h07;
  localparam logic [6:0] CNT_ADDR_LAST = 7'h1F;
  localparam logic [6:0] CNT_STATUS_FIRST = 7'h08;
  localparam logic [6:0] CNT_PAGE_DATA = 7'h40;
  localparam logic [6:0] CNT_BUF_DATA = 7'h28;
  localparam logic [6:0] CNT_TOP = 7'h7F;
  localparam logic [6:0] CNT_REENTER = 7'h78;
  localparam int PAGE_MSB = 19;
  localparam int PAGE_LSB = 9;
  localparam int BYTE_MSB = 8;

  // ************************************************************
  // array and buffers
  // ************************************************************
  localparam int PAGE_AW = 11;
  localparam int BYTE_AW = 9;
  localparam int ARR_AW = 20;
  localparam int BUF_AW = 10;
  localparam int BUF_WORDS = 528;
  localparam logic [8:0] LAST_BYTE = 9'h107;
  localparam logic [9:0] BUF2_BASE = 10'h108;
  localparam logic [1:0] SRC_ARR = 2'h0;
  localparam logic [1:0] SRC_BUF1 = 2'h1;
  localparam logic [1:0] SRC_BUF2 = 2'h2;
  // arbitrary value, not a real part's density code
  localparam logic [2:0] DENSITY_CODE = 3'h0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CORE_CLK_MHZ = 125;
  localparam int TRANSFER_COMPARE_TIME_NS = 4000;
  localparam int XFR_CYC = (TRANSFER_COMPARE_TIME_NS * CORE_CLK_MHZ + 999)
                           / 1000;
  localparam logic [9:0] XFR_LAST = 10'(XFR_CYC - 1);

  // ************************************************************
  // state types
  // ************************************************************
  typedef enum logic [1:0] {ENG_IDLE, ENG_RUN, ENG_DONE} sfr_eng_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic [31:0] sh;
    logic [7:0] op;
    logic [10:0] page;
    logic [8:0] ptr;
    logic [1:0] src;
    logic [7:0] cur;
    logic [7:0] hold;
    logic req;
    logic armed;
    logic ack_s1;
    logic ack_s2;
    logic rdy_s1;
    logic rdy_s2;
    logic cmp_s1;
    logic cmp_s2;
  } sfr_link_t;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic arm_s1;
    logic arm_s2;
    logic arm_s3;
    logic req_s1;
    logic req_s2;
    logic fack;
    logic fpend;
    logic [7:0] fdata;
    sfr_eng_t state;
    logic sel;
    logic cmp;
    logic [10:0] page;
    logic [8:0] idx;
    logic pend;
    logic [8:0] pidx;
    logic mism;
    logic cmp_res;
    logic rdy;
    logic [9:0] timer;
  } sfr_core_t;

endpackage : sfr_pkg

/* File: rtl/sfr_flash_read.sv */
// serial command front end: page read, buffer read, transfer, compare
`timescale 1ns/1ps

// Notes on behaviour
// (RULE1) serial input sampled on rising clock, output driven on falling.
// (RULE2) chip select fall starts a command: 8-bit opcode then address fields.
// (RULE3) each serial clock while selected shifts one input bit in.
// (RULE4) all opcodes, addresses and data travel most significant bit first.
// (RULE5) page read: 52H, 24 address bits, 32 don't-care bits, then data.
// (RULE6) address: four reserved bits ignored, 11 page bits, 9 byte bits.
// (RULE7) page read reads the array directly and never alters the buffers.
// (RULE8) after the header every further clock shifts the next data bit out.
// (RULE9) page read wraps from the last byte to the page's first byte.
// (RULE10) chip select rising ends any read and floats serial output.
// (RULE11) host keeps chip select low for the whole read sequence.
// (RULE12) buffer read: 54H reads buffer 1, 56H reads buffer 2.
// (RULE13) buffer read header: 15 don't-care, 9 address, 8 don't-care bits.
// (RULE14) buffer read wraps from the last byte to byte zero.
// (RULE15) transfer: 53H buffer 1, 55H buffer 2, reserved, page, don't-care.
// (RULE16) transfer starts only when chip select rises after its header.
// (RULE17) status stays readable during transfer and shows completion.
// (RULE18) compare: 60H buffer 1, 61H buffer 2, same header as transfer.
// (RULE19) compare checks all 264 page bytes against the chosen buffer.
// (RULE20) status shows busy throughout a compare.
// (RULE21) compare outcome lands in status bit 6 when it finishes.
// (RULE22) 57H shifts status out, bit 7 first, repeating while selected.
// (RULE23) status bit 7 is 1 when ready and 0 while busy.
// (RULE24) status bit 6 is 0 on match and 1 on any mismatch.
// (RULE25) unknown opcode keeps serial output floating until deselect.
module sfr_flash_read (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic spi_sck,
  input wire logic spi_cs_b,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  output logic arr_rd_en,
  output logic [19:0] arr_addr,
  input wire logic [7:0] arr_rd_data,
  output logic dev_ready,
  output logic cmp_mismatch
);

  // ************************************************************
  // link side, serial clock domain, cleared while deselected except the command fields
  // ************************************************************
  sfr_pkg::sfr_link_t lk_r;
  sfr_pkg::sfr_link_t lk_nxt;
  sfr_pkg::sfr_core_t co_r;
  sfr_pkg::sfr_core_t co_nxt;
  logic [31:0] sh_in;
  logic [7:0] cmd_op_r;
  logic [10:0] cmd_page_r;
  logic is_page;
  logic is_bufr;
  logic is_stat;
  logic drive_en;
  logic drive_bit;
  logic byte_load;
  logic [6:0] data_cnt;
  logic [7:0] stat_word;
  logic [2:0] bit_sel;
  logic [7:0] buf_mem [0:sfr_pkg::BUF_WORDS-1];
  logic buf_we;
  logic [9:0] buf_wa;
  logic [7:0] buf_wd;
  logic [9:0] eng_bidx;
  logic [9:0] fet_bidx;

  assign is_page = (lk_r.op == sfr_pkg::OP_PAGE_READ);
  assign is_bufr = (lk_r.op == sfr_pkg::OP_BUF1_READ) ||
                   (lk_r.op == sfr_pkg::OP_BUF2_READ);
  assign is_stat = (lk_r.op == sfr_pkg::OP_STATUS);
  // (RULE13) header length per opcode
  assign data_cnt = is_page ? sfr_pkg::CNT_PAGE_DATA : sfr_pkg::CNT_BUF_DATA;
  assign stat_word = {lk_r.rdy_s2, lk_r.cmp_s2, sfr_pkg::DENSITY_CODE, 3'h0};
  // (RULE4) msb first
  assign bit_sel = 3'h7 - lk_r.cnt[2:0];
  assign byte_load = (is_page || is_bufr) && (lk_r.cnt[2:0] == 3'h7) &&
                     (lk_r.cnt >= data_cnt - 7'h01);

  // (RULE25) unknown opcode never drives
  assign drive_en = (lk_r.cnt > sfr_pkg::CNT_OPCODE_LAST) &&
                    ((is_stat && lk_r.cnt >= sfr_pkg::CNT_STATUS_FIRST) ||
                     ((is_page || is_bufr) && lk_r.cnt >= data_cnt));
  // (RULE22) status repeats every eight clocks
  assign drive_bit = is_stat ? stat_word[bit_sel] : lk_r.cur[bit_sel];

  always_comb begin
    lk_nxt = lk_r;
    // (RULE3) one bit per rising edge
    sh_in = {lk_r.sh[30:0], spi_si};
    lk_nxt.sh = sh_in;
    lk_nxt.cnt = (lk_r.cnt == sfr_pkg::CNT_TOP) ? sfr_pkg::CNT_REENTER :
                 lk_r.cnt + 7'h01;
    lk_nxt.ack_s1 = co_r.fack;
    lk_nxt.ack_s2 = lk_r.ack_s1;
    lk_nxt.rdy_s1 = co_r.rdy;
    lk_nxt.rdy_s2 = lk_r.rdy_s1;
    lk_nxt.cmp_s1 = co_r.cmp_res;
    lk_nxt.cmp_s2 = lk_r.cmp_s1;
    // (RULE2) opcode in first eight bits
    if (lk_r.cnt == sfr_pkg::CNT_OPCODE_LAST) begin
      lk_nxt.op = sh_in[7:0];
    end
    if (lk_r.req && lk_r.ack_s2) begin
      lk_nxt.req = 1'b0;
      lk_nxt.hold = co_r.fdata;
    end
    if (lk_r.cnt == sfr_pkg::CNT_ADDR_LAST) begin
      // (RULE6) reserved bits dropped, page and byte fields
      lk_nxt.page = sh_in[sfr_pkg::PAGE_MSB:sfr_pkg::PAGE_LSB];
      lk_nxt.ptr = sh_in[sfr_pkg::BYTE_MSB:0];
      if (is_page) begin
        // (RULE5) page read fetches first byte early
        lk_nxt.src = sfr_pkg::SRC_ARR;
        lk_nxt.req = 1'b1;
      end else if (is_bufr) begin
        // (RULE12) buffer chosen by opcode
        lk_nxt.src = (lk_r.op == sfr_pkg::OP_BUF1_READ) ? sfr_pkg::SRC_BUF1 :
                     sfr_pkg::SRC_BUF2;
        lk_nxt.req = 1'b1;
      end else if ((lk_r.op == sfr_pkg::OP_XFER1) ||
                   (lk_r.op == sfr_pkg::OP_XFER2) ||
                   (lk_r.op == sfr_pkg::OP_CMP1) ||
                   (lk_r.op == sfr_pkg::OP_CMP2)) begin
        lk_nxt.armed = 1'b1;
      end
    end
    // (RULE8) next byte loaded at each byte boundary
    if (byte_load) begin
      lk_nxt.cur = lk_r.hold;
      // (RULE9) (RULE14) wrap inside page or buffer
      lk_nxt.ptr = (lk_r.ptr >= sfr_pkg::LAST_BYTE) ? 9'h000 :
                   lk_r.ptr + 9'h001;
      lk_nxt.req = 1'b1;
    end
  end

  // (RULE10) deselect clears the link and ends reads
  always_ff @(posedge spi_sck or posedge spi_cs_b) begin
    if (spi_cs_b) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // (RULE15) command fields outlive the frame for the core side
  always_ff @(posedge spi_sck) begin
    if (!spi_cs_b && lk_r.cnt == sfr_pkg::CNT_ADDR_LAST) begin
      cmd_op_r <= lk_r.op;
      cmd_page_r <= sh_in[sfr_pkg::PAGE_MSB:sfr_pkg::PAGE_LSB];
    end
  end

  // (RULE1) output changes on the falling edge
  always_ff @(negedge spi_sck or posedge spi_cs_b) begin
    if (spi_cs_b) begin
      spi_so <= 1'b0;
      spi_so_oe <= 1'b0;
    end else begin
      spi_so <= drive_bit;
      spi_so_oe <= drive_en;
    end
  end

  // ************************************************************
  // core side: byte fetch and transfer / compare engine
  // ************************************************************
  assign fet_bidx = {1'b0, lk_r.ptr} +
                    ((lk_r.src == sfr_pkg::SRC_BUF2) ? sfr_pkg::BUF2_BASE :
                     10'h000);
  assign eng_bidx = {1'b0, co_r.pidx} +
                    (co_r.sel ? sfr_pkg::BUF2_BASE : 10'h000);

  always_comb begin
    co_nxt = co_r;
    arr_rd_en = 1'b0;
    arr_addr = 20'h00000;
    buf_we = 1'b0;
    buf_wa = eng_bidx;
    buf_wd = arr_rd_data;
    co_nxt.cs_s1 = spi_cs_b;
    co_nxt.cs_s2 = co_r.cs_s1;
    co_nxt.arm_s1 = lk_r.armed;
    co_nxt.arm_s2 = co_r.arm_s1;
    co_nxt.arm_s3 = co_r.arm_s2;
    co_nxt.req_s1 = lk_r.req;
    co_nxt.req_s2 = co_r.req_s1;
    co_nxt.pend = 1'b0;
    if (co_r.fpend) begin
      co_nxt.fdata = arr_rd_data;
      co_nxt.fack = 1'b1;
      co_nxt.fpend = 1'b0;
    end else if (!co_r.req_s2) begin
      co_nxt.fack = 1'b0;
    end else if (!co_r.fack) begin
      if (lk_r.src != sfr_pkg::SRC_ARR) begin
        co_nxt.fdata = buf_mem[fet_bidx];
        co_nxt.fack = 1'b1;
      end else if (co_r.state == sfr_pkg::ENG_IDLE) begin
        // (RULE7) page read goes to the array only
        arr_rd_en = 1'b1;
        arr_addr = {lk_r.page, lk_r.ptr};
        co_nxt.fpend = 1'b1;
      end
    end
    if (co_r.pend) begin
      if (co_r.cmp) begin
        // (RULE24) any differing bit marks a mismatch
        co_nxt.mism = co_r.mism | (arr_rd_data != buf_mem[eng_bidx]);
      end else begin
        buf_we = 1'b1;
      end
    end
    if (co_r.state != sfr_pkg::ENG_IDLE) begin
      co_nxt.timer = co_r.timer + 10'h001;
    end
    case (co_r.state)
      sfr_pkg::ENG_IDLE: begin
        // (RULE16) launch on deselect after a loaded header
        if (co_r.arm_s3 && !co_r.arm_s2) begin
          co_nxt.state = sfr_pkg::ENG_RUN;
          co_nxt.sel = (cmd_op_r == sfr_pkg::OP_XFER2) ||
                       (cmd_op_r == sfr_pkg::OP_CMP2);
          // (RULE18) compare opcodes
          co_nxt.cmp = (cmd_op_r == sfr_pkg::OP_CMP1) ||
                       (cmd_op_r == sfr_pkg::OP_CMP2);
          co_nxt.page = cmd_page_r;
          co_nxt.idx = 9'h000;
          co_nxt.timer = 10'h000;
          co_nxt.mism = 1'b0;
        end
      end
      sfr_pkg::ENG_RUN: begin
        // (RULE19) walk every byte of the page
        arr_rd_en = 1'b1;
        arr_addr = {co_r.page, co_r.idx};
        co_nxt.pend = 1'b1;
        co_nxt.pidx = co_r.idx;
        if (co_r.idx == sfr_pkg::LAST_BYTE) begin
          co_nxt.state = sfr_pkg::ENG_DONE;
        end else begin
          co_nxt.idx = co_r.idx + 9'h001;
        end
      end
      sfr_pkg::ENG_DONE: begin
        if (!co_r.pend && co_r.timer >= sfr_pkg::XFR_LAST) begin
          co_nxt.state = sfr_pkg::ENG_IDLE;
          // (RULE21) result lands at completion
          if (co_r.cmp) begin
            co_nxt.cmp_res = co_r.mism;
          end
        end
      end
      default: begin
        co_nxt.state = sfr_pkg::ENG_IDLE;
      end
    endcase
    // (RULE20) busy through compare
    // (RULE23) ready only while idle
    co_nxt.rdy = (co_nxt.state == sfr_pkg::ENG_IDLE);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      co_r <= '0;
      co_r.rdy <= 1'b1;
      co_r.state <= sfr_pkg::ENG_IDLE;
    end else begin
      co_r <= co_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (buf_we) begin
      buf_mem[buf_wa] <= buf_wd;
    end
  end

  // (RULE17) status bits exported
  assign dev_ready = co_r.rdy;
  assign cmp_mismatch = co_r.cmp_res;

  // ************************************************************
  // assertions and covers
  // ************************************************************
  a_launch_busy: assert property ( // (RULE16)
    @(posedge core_clk) disable iff (!rst_b)
    (co_r.state == sfr_pkg::ENG_IDLE && co_r.arm_s3 && !co_r.arm_s2)
    |=> !co_r.rdy && co_r.state == sfr_pkg::ENG_RUN)
    else $error("engine did not start on deselect");

  a_busy_span: assert property ( // (RULE20)
    @(posedge core_clk) disable iff (!rst_b)
    $fell(co_r.rdy) |-> !co_r.rdy [*8])
    else $error("busy dropped too early");

  a_run_end: assert property ( // (RULE19)
    @(posedge core_clk) disable iff (!rst_b)
    (co_r.state == sfr_pkg::ENG_RUN && co_r.idx == sfr_pkg::LAST_BYTE)
    |=> co_r.state == sfr_pkg::ENG_DONE && co_r.pend)
    else $error("last byte not compared");

  a_cmp_result: assert property ( // (RULE21)
    @(posedge core_clk) disable iff (!rst_b)
    ($rose(co_r.rdy) && co_r.cmp) |-> co_r.cmp_res == $past(co_r.mism))
    else $error("compare outcome not stored");

  a_buf_kept: assert property ( // (RULE7)
    @(posedge core_clk) disable iff (!rst_b)
    buf_we |-> !co_r.cmp && $past(co_r.state) == sfr_pkg::ENG_RUN)
    else $error("buffer written outside a transfer");

  a_fetch_buf: assert property ( // (RULE12)
    @(posedge core_clk) disable iff (!rst_b)
    ($rose(co_r.req_s2) && lk_r.src != sfr_pkg::SRC_ARR && !co_r.fack)
    |=> co_r.fack)
    else $error("buffer byte not returned");

  a_deselect_float: assert property ( // (RULE10)
    @(posedge core_clk) disable iff (!rst_b)
    co_r.cs_s2 |-> !spi_so_oe)
    else $error("output driven while deselected");

  a_wrap_ptr: assert property ( // (RULE14)
    @(posedge spi_sck) disable iff (spi_cs_b)
    (byte_load && lk_r.ptr == sfr_pkg::LAST_BYTE) |=> lk_r.ptr == 9'h000)
    else $error("pointer failed to wrap");

  a_header_quiet: assert property ( // (RULE13)
    @(posedge spi_sck) disable iff (spi_cs_b)
    (lk_r.cnt < sfr_pkg::CNT_STATUS_FIRST ||
     is_bufr && lk_r.cnt < sfr_pkg::CNT_BUF_DATA) |-> !spi_so_oe)
    else $error("output driven during header");

  a_status_out: assert property ( // (RULE22)
    @(posedge spi_sck) disable iff (spi_cs_b)
    (is_stat && lk_r.cnt == sfr_pkg::CNT_STATUS_FIRST)
    |-> drive_en && drive_bit == lk_r.rdy_s2)
    else $error("status bit 7 not first");

  a_unknown_quiet: assert property ( // (RULE25)
    @(posedge spi_sck) disable iff (spi_cs_b)
    (!is_stat && !is_page && !is_bufr) |-> !drive_en)
    else $error("unknown opcode drove output");

  c_page_read: cover property (
    @(posedge spi_sck) disable iff (spi_cs_b)
    is_page && byte_load && lk_r.ptr == sfr_pkg::LAST_BYTE);
  c_buf_read: cover property (
    @(posedge spi_sck) disable iff (spi_cs_b)
    is_bufr && lk_r.cnt == sfr_pkg::CNT_BUF_DATA);
  c_compare_fail: cover property (
    @(posedge core_clk) disable iff (!rst_b)
    $rose(co_r.cmp_res));
  c_transfer_done: cover property (
    @(posedge core_clk) disable iff (!rst_b)
    $rose(co_r.rdy) && !co_r.cmp);

endmodule : sfr_flash_read

/* File: tb/sfr_array_model.sv */
// behavioural flash array behind the engine's memory port
`timescale 1ns/1ps
module sfr_array_model (
  input wire logic core_clk,
  input wire logic arr_rd_en,
  input wire logic [19:0] arr_addr,
  output logic [7:0] arr_rd_data
);
  logic [7:0] q_r = 8'h5A;

  // ************************************************************
  // read port
  // ************************************************************
  // data valid only the cycle after the strobe, churning otherwise
  always @(posedge core_clk) begin
    if (arr_rd_en) begin
      q_r <= arr_addr[7:0] + arr_addr[16:9] + {arr_addr[8], 7'h00};
    end else begin
      q_r <= ~q_r;
    end
  end
  assign arr_rd_data = q_r;
endmodule : sfr_array_model

/* File: tb/sfr_flash_read_tb.sv */
// self-checking bench for the serial flash read engine
`timescale 1ns/1ps
module sfr_flash_read_tb;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic spi_sck = 1'b0;
  logic spi_cs_b = 1'b0;
  logic spi_si = 1'b0;
  logic spi_so;
  logic spi_so_oe;
  logic arr_rd_en;
  logic [19:0] arr_addr;
  logic [7:0] arr_rd_data;
  logic dev_ready;
  logic cmp_mismatch;
  logic oe_seen = 1'b0;
  logic cpol = 1'b0;
  int fails = 0;
  int n_compared = 0;

  always #4 core_clk = ~core_clk;

  sfr_flash_read u_dut (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .spi_sck(spi_sck),
    .spi_cs_b(spi_cs_b),
    .spi_si(spi_si),
    .spi_so(spi_so),
    .spi_so_oe(spi_so_oe),
    .arr_rd_en(arr_rd_en),
    .arr_addr(arr_addr),
    .arr_rd_data(arr_rd_data),
    .dev_ready(dev_ready),
    .cmp_mismatch(cmp_mismatch)
  );

  sfr_array_model u_arr (
    .core_clk(core_clk),
    .arr_rd_en(arr_rd_en),
    .arr_addr(arr_addr),
    .arr_rd_data(arr_rd_data)
  );

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [7:0] pat(input logic [10:0] pg,
                                     input logic [8:0] by);
    return by[7:0] + pg[7:0] + {by[8], 7'h00};
  endfunction : pat

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask : chk

  task automatic conclude();
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : conclude

  // ************************************************************
  // serial host, mode 0 or 3, 32 ns clock only inside frames
  // ************************************************************
  task automatic bit_x(input logic o, output logic i);
    if (cpol) begin
      spi_sck <= 1'b0;
    end
    spi_si <= o;
    #16;
    spi_sck <= 1'b1;
    i = spi_so;
    oe_seen = oe_seen | spi_so_oe;
    #16;
    if (!cpol) begin
      spi_sck <= 1'b0;
    end
  endtask : bit_x

  task automatic send(input logic [31:0] w, input int n);
    logic d;
    for (int k = 31; k > 31 - n; k--) begin
      bit_x(w[k], d);
    end
  endtask : send

  task automatic rd(output logic [7:0] b);
    logic d;
    for (int k = 0; k < 8; k++) begin
      bit_x(1'b0, d);
      b = {b[6:0], d};
    end
  endtask : rd

  task automatic cs_lo();
    spi_cs_b <= 1'b0;
    oe_seen = 1'b0;
    #13;
  endtask : cs_lo

  task automatic cs_hi();
    #16;
    spi_cs_b <= 1'b1;
    #5;
    chk("so_oe_idle", 8'h00, {7'h00, spi_so_oe});
    #35;
  endtask : cs_hi

  task automatic wait_rdy(input logic e, input int bound);
    int k;
    k = 0;
    while (dev_ready !== e && k < bound) begin
      @(posedge core_clk);
      #1;
      k++;
    end
    if (dev_ready !== e) begin
      chk("dev_ready_wait", {7'h00, e}, {7'h00, dev_ready});
      conclude();
    end
  endtask : wait_rdy

  // status byte read twice in one frame, compared under a mask
  task automatic st(input logic [7:0] e, input logic [7:0] m);
    logic [7:0] b;
    cs_lo();
    send({8'h57, 24'h000000}, 8);
    for (int k = 0; k < 2; k++) begin
      rd(b);
      chk("status", e & m, b & m);
    end
    cs_hi();
  endtask : st

  // read with header w, ndc don't-care bits, three bytes
  task automatic xrd(input logic [31:0] w, input int ndc,
                     input logic [10:0] pg, input logic [8:0] a);
    logic [7:0] b;
    cs_lo();
    send(w, 32);
    send(32'h00000000, ndc);
    chk("so_oe_header", 8'h00, {7'h00, oe_seen});
    for (int j = 0; j < 3; j++) begin
      rd(b);
      chk("read_data", pat(pg, 9'((a + j) % 264)), b);
    end
    cs_hi();
  endtask : xrd

  // transfer or compare, busy seen in status, then ready again
  task automatic run_op(input logic [7:0] op, input logic [10:0] pg);
    cs_lo();
    send({op, 4'hF, pg, 9'h1FF}, 32);
    chk("ready_before_cs", 8'h01, {7'h00, dev_ready});
    cs_hi();
    wait_rdy(1'b0, 20);
    st(8'h00, 8'h80);
    wait_rdy(1'b1, 1000);
  endtask : run_op

  // ************************************************************
  // main sequence
  // ************************************************************
  logic [7:0] cop [4] = '{8'h60, 8'h61, 8'h61, 8'h60};
  logic [10:0] cpg [4] = '{11'h005, 11'h005, 11'h006, 11'h006};
  logic cexp [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  initial begin
    logic [7:0] b;
    // rising select clears the link logic before the first frame
    spi_cs_b <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    chk("dev_ready", 8'h01, {7'h00, dev_ready});
    chk("cmp_mismatch", 8'h00, {7'h00, cmp_mismatch});
    st(8'h80, 8'hF8);
    run_op(8'h53, 11'h005);
    xrd({8'h52, 4'hF, 11'h006, 9'h106}, 32, 11'h006, 9'h106);
    xrd({8'h54, 15'h7FFF, 9'h107}, 8, 11'h005, 9'h107);
    run_op(8'h55, 11'h006);
    xrd({8'h56, 15'h0000, 9'h000}, 8, 11'h006, 9'h000);
    for (int k = 0; k < 4; k++) begin
      run_op(cop[k], cpg[k]);
      chk("cmp_mismatch", {7'h00, cexp[k]}, {7'h00, cmp_mismatch});
      st({1'b1, cexp[k], 6'h00}, 8'hC0);
    end
    // remaining frames in mode 3, clock idling high
    cpol = 1'b1;
    spi_sck <= 1'b1;
    #32;
    xrd({8'h52, 4'hF, 11'h005, 9'h000}, 32, 11'h005, 9'h000);
    cs_lo();
    send({8'hA5, 24'h000000}, 32);
    send(32'h00000000, 32);
    rd(b);
    chk("so_oe_unknown_op", 8'h00, {7'h00, oe_seen});
    cs_hi();
    conclude();
  end
endmodule : sfr_flash_read_tb
